// file: core/lfm_pkg.sv
`default_nettype none

package lfm_pkg;

    localparam int NCH = 2;

    // Consecutive qualifying cycles before a short is declared.
    localparam logic [3:0] FB_SHORT_CYCLES    = 4'h8;
    localparam logic [3:0] BOOST_SHORT_CYCLES = 4'h2;

    // Short threshold field width and its value after reset.
    localparam int         THR_W     = 4;
    localparam logic [3:0] THR_RESET = 4'h2;

    // Width of the coded LED current level per channel.
    localparam int LVL_W = 2;

    // Dead time between a short shutdown and the restart soft start.
    localparam int         CLK_PERIOD_NS = 8;
    localparam int         OFF_TIME_NS   = 128;
    localparam int         OFF_CYCLES    = (OFF_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int         OFF_CNT_W     = 5;
    localparam logic [4:0] OFF_CNT       = 5'(OFF_CYCLES);

    typedef enum logic [1:0] {
        CH_SOFT = 2'b00,
        CH_RUN  = 2'b01,
        CH_OFF  = 2'b10
    } lfm_ch_state_t;

endpackage : lfm_pkg

`default_nettype wire

// file: core/lfm_det_if.sv
`timescale 1ns/100ps
`default_nettype none

interface lfm_det_if;
    logic en;
    logic blank;
    logic boost;
    logic fb_low;
    logic ovc;
    logic hs_low;
    logic det;
    logic s2g;

    modport ctrl_mp (output en, output blank, output boost, output fb_low, output ovc,
                     output hs_low, input det, input s2g);
    modport det_mp  (input en, input blank, input boost, input fb_low, input ovc,
                     input hs_low, output det, output s2g);
endinterface : lfm_det_if

`default_nettype wire

// file: core/lfm_short_det.sv
`timescale 1ns/100ps
`default_nettype none

module lfm_short_det (
    input  wire logic   clk_i,
    input  wire logic   resetn_i,
    lfm_det_if.det_mp   dif
);

    typedef struct packed {
        logic [3:0] fb_cnt;
        logic [3:0] ovc_cnt;
        logic [3:0] hs_cnt;
        logic       det;
        logic       s2g;
    } lfm_det_state_t;

    lfm_det_state_t cur_ff;
    lfm_det_state_t nxt_det;

    function automatic logic [3:0] sat_inc(input logic cond, input logic [3:0] cnt,
                                           input logic [3:0] lim);
        if (!cond) begin
            return 4'h0;
        end
        return (cnt >= lim) ? lim : cnt + 4'h1;
    endfunction : sat_inc

    always_comb begin
        nxt_det = cur_ff;
        // Blanking during the soft-start ramp only hides the feedback comparator.
        nxt_det.fb_cnt  = sat_inc(dif.en && !dif.blank && dif.fb_low, cur_ff.fb_cnt,
                                  lfm_pkg::FB_SHORT_CYCLES);
        nxt_det.ovc_cnt = sat_inc(dif.en && dif.boost && dif.ovc, cur_ff.ovc_cnt,
                                  lfm_pkg::BOOST_SHORT_CYCLES);
        nxt_det.hs_cnt  = sat_inc(dif.en && dif.boost && dif.hs_low, cur_ff.hs_cnt,
                                  lfm_pkg::BOOST_SHORT_CYCLES);
        nxt_det.s2g     = nxt_det.hs_cnt == lfm_pkg::BOOST_SHORT_CYCLES;
        nxt_det.det     = (nxt_det.fb_cnt == lfm_pkg::FB_SHORT_CYCLES)
                        || (nxt_det.ovc_cnt == lfm_pkg::BOOST_SHORT_CYCLES)
                        || nxt_det.s2g;
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_det;
        end
    end

    assign dif.det = cur_ff.det;
    assign dif.s2g = cur_ff.s2g;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    sequence fb_qual_s;
        (dif.en && !dif.blank && dif.fb_low) [*8];
    endsequence

    fb_short_a : assert property (fb_qual_s |=> dif.det)
        else $error("feedback short not declared after eight cycles");
    ovc_short_a : assert property ((dif.en && dif.boost && dif.ovc) [*2] |=> dif.det)
        else $error("overcurrent short not declared after two cycles");
    hs_short_a : assert property ((dif.en && dif.boost && dif.hs_low) [*2] |=> dif.det && dif.s2g)
        else $error("sense short to ground not declared after two cycles");
    blank_fb_a : assert property (dif.blank |=> cur_ff.fb_cnt == 4'h0)
        else $error("feedback count advanced during blanking");
    count_clear_a : assert property (!dif.fb_low |=> cur_ff.fb_cnt == 4'h0)
        else $error("feedback count not cleared");
    det_cause_a : assert property (dif.det |-> $past(dif.en))
        else $error("short declared with detection disabled");

endmodule : lfm_short_det

`default_nettype wire

// file: core/lfm_fault_mon.sv
// Behaviour
// - Feedback below short threshold eight consecutive cycles declares a short.
// - Boost: load overcurrent two consecutive cycles declares a short.
// - Boost: high sense pin below ground threshold two cycles declares a short.
// - Feedback short ignored during soft-start rise until blanking level passed.
// - A short sets the channel short flag and stops the gate drivers.
// - After a short shutdown the channel restarts through soft start by itself.
// - Buck strap: monitor pin carries output current feedback, select bit ignored.
// - Boost, select low: monitor pin carries PWM activity with short-to-ground flag.
// - Boost, select high: monitor pin carries output current feedback.
// - Entering limp home returns all settings, monitor select included, to reset.
// - In idle only temperature and undervoltage faults are reported.
// - Overtemperature shutdown overrules every other fault action.
// - A 4-bit field per channel sets the short threshold.
// - A two-bit coded LED current level per channel is readable.
`timescale 1ns/100ps
`default_nettype none

module lfm_fault_mon (
    input  wire logic        CLK_I,
    input  wire logic        RESETN_I,
    input  wire logic [1:0]  TOPOLOGY_STRAP_I,
    input  wire logic [1:0]  FB_BELOW_THR_I,
    input  wire logic [1:0]  LOAD_OVC_I,
    input  wire logic [1:0]  SENSE_HIGH_LOW_I,
    input  wire logic [1:0]  SS_BLANK_PASSED_I,
    input  wire logic [1:0]  SS_DONE_I,
    input  wire logic [1:0]  PWM_ACTIVE_I,
    input  wire logic [1:0]  IOUT_FB_I,
    input  wire logic [3:0]  LED_LEVEL_I,
    input  wire logic        IDLE_I,
    input  wire logic        LIMP_HOME_I,
    input  wire logic        OT_SHDN_I,
    input  wire logic        OT_WARN_I,
    input  wire logic        GATE_UV_I,
    input  wire logic        LOGIC_UV_I,
    input  wire logic [1:0]  MON_SEL_WR_I,
    input  wire logic        MON_SEL_WDATA_I,
    input  wire logic [1:0]  THR_WR_I,
    input  wire logic [3:0]  THR_WDATA_I,
    input  wire logic [1:0]  FLAG_CLR_I,
    output logic      [1:0]  SHORT_FLAG_O,
    output logic      [1:0]  GATE_EN_O,
    output logic      [1:0]  SOFT_START_O,
    output logic      [1:0]  MON_PIN_O,
    output logic      [1:0]  MON_SEL_O,
    output logic      [7:0]  THRESHOLD_O,
    output logic      [3:0]  CURR_LEVEL_O,
    output logic             OT_SHDN_FLAG_O,
    output logic             OT_WARN_FLAG_O,
    output logic             GATE_UV_FLAG_O,
    output logic             LOGIC_UV_FLAG_O
);

    localparam int NCH = lfm_pkg::NCH;

    typedef struct packed {
        lfm_pkg::lfm_ch_state_t [NCH-1:0]                       st;
        logic [NCH-1:0][lfm_pkg::OFF_CNT_W-1:0]                 off_cnt;
        logic [NCH-1:0][lfm_pkg::THR_W-1:0]                     thr;
        logic [NCH-1:0][lfm_pkg::LVL_W-1:0]                     lvl;
        logic [NCH-1:0]                                         flag;
        logic [NCH-1:0]                                         gate;
        logic [NCH-1:0]                                         ss;
        logic [NCH-1:0]                                         mon;
        logic [NCH-1:0]                                         sel;
        logic [3:0]                                             sys;
    } lfm_top_state_t;

    lfm_top_state_t cur_ff;
    lfm_top_state_t nxt_top;
    logic [NCH-1:0] det;
    logic [NCH-1:0] s2g;

    for (genvar g = 0; g < NCH; g++) begin : g_ch
        lfm_det_if dif ();
        assign dif.en     = cur_ff.gate[g];
        assign dif.blank  = (cur_ff.st[g] == lfm_pkg::CH_SOFT) && !SS_BLANK_PASSED_I[g];
        assign dif.boost  = TOPOLOGY_STRAP_I[g];
        assign dif.fb_low = FB_BELOW_THR_I[g];
        assign dif.ovc    = LOAD_OVC_I[g];
        assign dif.hs_low = SENSE_HIGH_LOW_I[g];
        assign det[g]     = dif.det;
        assign s2g[g]     = dif.s2g;
        lfm_short_det u_det (
            .clk_i    (CLK_I),
            .resetn_i (RESETN_I),
            .dif      (dif)
        );
    end

    always_comb begin
        nxt_top = cur_ff;
        // Temperature and supply faults are reported in every state, idle included.
        nxt_top.sys = {OT_SHDN_I, OT_WARN_I, GATE_UV_I, LOGIC_UV_I};
        for (int c = 0; c < NCH; c++) begin
            nxt_top.lvl[c] = LED_LEVEL_I[c*2 +: 2];
            if (MON_SEL_WR_I[c]) begin
                nxt_top.sel[c] = MON_SEL_WDATA_I;
            end
            if (THR_WR_I[c]) begin
                nxt_top.thr[c] = THR_WDATA_I;
            end
            if (FLAG_CLR_I[c]) begin
                nxt_top.flag[c] = 1'b0;
            end
            // A new short beats a clear in the same cycle; idle reports none.
            if (det[c] && !IDLE_I) begin
                nxt_top.flag[c] = 1'b1;
            end
            case (cur_ff.st[c])
                lfm_pkg::CH_SOFT: begin
                    nxt_top.gate[c] = 1'b1;
                    if (SS_DONE_I[c]) begin
                        nxt_top.st[c] = lfm_pkg::CH_RUN;
                    end
                end
                lfm_pkg::CH_RUN: begin
                    nxt_top.gate[c] = 1'b1;
                end
                lfm_pkg::CH_OFF: begin
                    nxt_top.gate[c] = 1'b0;
                    if (cur_ff.off_cnt[c] == '0) begin
                        nxt_top.st[c] = lfm_pkg::CH_SOFT;
                    end else begin
                        nxt_top.off_cnt[c] = cur_ff.off_cnt[c] - 5'h1;
                    end
                end
                default: begin
                    nxt_top.st[c] = lfm_pkg::CH_OFF;
                end
            endcase
            if ((det[c] && !IDLE_I) || OT_SHDN_I || IDLE_I) begin
                // Overtemperature holds the channel off until it is gone.
                nxt_top.st[c]      = lfm_pkg::CH_OFF;
                nxt_top.off_cnt[c] = lfm_pkg::OFF_CNT;
                nxt_top.gate[c]    = 1'b0;
            end
            nxt_top.ss[c] = (nxt_top.st[c] == lfm_pkg::CH_SOFT);
            if (!TOPOLOGY_STRAP_I[c] || cur_ff.sel[c]) begin
                nxt_top.mon[c] = IOUT_FB_I[c];
            end else begin
                nxt_top.mon[c] = PWM_ACTIVE_I[c] && !s2g[c];
            end
        end
        if (LIMP_HOME_I) begin
            nxt_top.sel  = '0;
            nxt_top.thr  = {NCH{lfm_pkg::THR_RESET}};
            nxt_top.flag = '0;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RESETN_I) begin
            cur_ff     <= '0;
            cur_ff.thr <= {NCH{lfm_pkg::THR_RESET}};
        end else begin
            cur_ff <= nxt_top;
        end
    end

    assign SHORT_FLAG_O    = cur_ff.flag;
    assign GATE_EN_O       = cur_ff.gate;
    assign SOFT_START_O    = cur_ff.ss;
    assign MON_PIN_O       = cur_ff.mon;
    assign MON_SEL_O       = cur_ff.sel;
    assign THRESHOLD_O     = cur_ff.thr;
    assign CURR_LEVEL_O    = cur_ff.lvl;
    assign OT_SHDN_FLAG_O  = cur_ff.sys[3];
    assign OT_WARN_FLAG_O  = cur_ff.sys[2];
    assign GATE_UV_FLAG_O  = cur_ff.sys[1];
    assign LOGIC_UV_FLAG_O = cur_ff.sys[0];

    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RESETN_I);

    for (genvar a = 0; a < NCH; a++) begin : g_chk
        sequence short_hit_s;
            det[a] && !IDLE_I && !LIMP_HOME_I;
        endsequence
        sequence restart_due_s;
            cur_ff.st[a] == lfm_pkg::CH_OFF && cur_ff.off_cnt[a] == '0
                && !det[a] && !OT_SHDN_I && !IDLE_I;
        endsequence

        short_flag_a : assert property (short_hit_s |=> SHORT_FLAG_O[a] && !GATE_EN_O[a])
            else $error("short did not set flag and stop gate");
        auto_restart_a : assert property (restart_due_s |=> SOFT_START_O[a] ##1 GATE_EN_O[a])
            else $error("channel did not restart through soft start");
        buck_mon_a : assert property (!TOPOLOGY_STRAP_I[a] |=> MON_PIN_O[a] == $past(IOUT_FB_I[a]))
            else $error("buck monitor pin not current feedback");
        boost_pwm_a : assert property (TOPOLOGY_STRAP_I[a] && !MON_SEL_O[a]
            |=> MON_PIN_O[a] == $past(PWM_ACTIVE_I[a] && !s2g[a]))
            else $error("boost monitor pin not pwm copy");
        boost_fb_a : assert property (TOPOLOGY_STRAP_I[a] && MON_SEL_O[a]
            |=> MON_PIN_O[a] == $past(IOUT_FB_I[a]))
            else $error("boost monitor pin not current feedback");
        idle_mask_a : assert property (IDLE_I && !SHORT_FLAG_O[a] |=> !SHORT_FLAG_O[a])
            else $error("short reported in idle");
        thr_write_a : assert property (THR_WR_I[a] && !LIMP_HOME_I
            |=> THRESHOLD_O[a*4 +: 4] == $past(THR_WDATA_I))
            else $error("threshold field not written");
        level_a : assert property (1'b1 |=> CURR_LEVEL_O[a*2 +: 2] == $past(LED_LEVEL_I[a*2 +: 2]))
            else $error("current level not reported");
    end

    limp_reset_a : assert property (LIMP_HOME_I |=> MON_SEL_O == '0
        && THRESHOLD_O == {NCH{lfm_pkg::THR_RESET}} && SHORT_FLAG_O == '0)
        else $error("limp home did not reset settings");
    ot_prio_a : assert property (OT_SHDN_I [*2] |=> GATE_EN_O == '0 && SOFT_START_O == '0)
        else $error("overtemperature did not hold channels off");

    idle_off_a : assert property (IDLE_I |=> GATE_EN_O == '0)
        else $error("channel switching in idle");
    warn_report_a : assert property (1'b1 |=> OT_WARN_FLAG_O == $past(OT_WARN_I))
        else $error("overtemperature warning not reported");
    uv_report_a : assert property (1'b1 |=> GATE_UV_FLAG_O == $past(GATE_UV_I)
        && LOGIC_UV_FLAG_O == $past(LOGIC_UV_I))
        else $error("undervoltage fault not reported");

endmodule : lfm_fault_mon

`default_nettype wire

// file: testbench/lfm_mcu_model.sv
`timescale 1ns/100ps
`default_nettype none

module lfm_mcu_model (
    input  wire logic       clk_i,
    output logic      [1:0] sel_wr_o,
    output logic            sel_wdata_o,
    output logic      [1:0] thr_wr_o,
    output logic      [3:0] thr_wdata_o,
    output logic      [1:0] clr_o
);
    initial begin
        sel_wr_o    = 2'h0;
        sel_wdata_o = 1'b0;
        thr_wr_o    = 2'h0;
        thr_wdata_o = 4'h0;
        clr_o       = 2'h0;
    end

    // Kind 0 writes the select bit, 1 the threshold field, 2 clears a flag.
    task automatic access(input logic [1:0] k, input int ch, input logic [3:0] d);
        @(negedge clk_i);
        case (k)
            2'h0: begin
                sel_wr_o[ch] = 1'b1;
                sel_wdata_o  = d[0];
            end
            2'h1: begin
                thr_wr_o[ch] = 1'b1;
                thr_wdata_o  = d;
            end
            default: clr_o[ch] = 1'b1;
        endcase
        @(negedge clk_i);
        sel_wr_o    = 2'h0;
        thr_wr_o    = 2'h0;
        clr_o       = 2'h0;
        sel_wdata_o = ~d[0];
        thr_wdata_o = ~d;
    endtask : access
endmodule : lfm_mcu_model

`default_nettype wire

// file: testbench/lfm_fault_mon_tb.sv
`timescale 1ns/100ps
`default_nettype none

module lfm_fault_mon_tb;
    logic       clk, rstn, idle, limp, ots, otw, guv, luv, swd, fo, fw, fg, fl;
    logic [1:0] strap, fb, ovc, shl, blk, ssd, pwm, iof, swr, thw, clr;
    logic [1:0] flg, gen, sst, mpin, msel, es;
    logic [3:0] lvl, thd, cl;
    logic [7:0] thr, et;
    logic [31:0] rs, v;
    int         bad_count, n_checks;

    lfm_mcu_model i_lfm_mcu_model (.clk_i(clk), .sel_wr_o(swr), .sel_wdata_o(swd),
        .thr_wr_o(thw), .thr_wdata_o(thd), .clr_o(clr));

    lfm_fault_mon i_lfm_fault_mon (.CLK_I(clk), .RESETN_I(rstn), .TOPOLOGY_STRAP_I(strap),
        .FB_BELOW_THR_I(fb), .LOAD_OVC_I(ovc), .SENSE_HIGH_LOW_I(shl),
        .SS_BLANK_PASSED_I(blk), .SS_DONE_I(ssd), .PWM_ACTIVE_I(pwm), .IOUT_FB_I(iof),
        .LED_LEVEL_I(lvl), .IDLE_I(idle), .LIMP_HOME_I(limp), .OT_SHDN_I(ots),
        .OT_WARN_I(otw), .GATE_UV_I(guv), .LOGIC_UV_I(luv), .MON_SEL_WR_I(swr),
        .MON_SEL_WDATA_I(swd), .THR_WR_I(thw), .THR_WDATA_I(thd), .FLAG_CLR_I(clr),
        .SHORT_FLAG_O(flg), .GATE_EN_O(gen), .SOFT_START_O(sst), .MON_PIN_O(mpin),
        .MON_SEL_O(msel), .THRESHOLD_O(thr), .CURR_LEVEL_O(cl), .OT_SHDN_FLAG_O(fo),
        .OT_WARN_FLAG_O(fw), .GATE_UV_FLAG_O(fg), .LOGIC_UV_FLAG_O(fl));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    function automatic logic [31:0] xs();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction : xs

    // Buck, or boost with select high, shows current feedback; else PWM activity.
    function automatic logic [1:0] mon_exp(input logic [1:0] s, input logic [1:0] m);
        for (int c = 0; c < 2; c++) begin
            mon_exp[c] = (!s[c] || m[c]) ? iof[c] : pwm[c];
        end
    endfunction : mon_exp

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc

    // Holds one fault condition for n edges, then lets the flag settle.
    task automatic hold(input int k, input int ch, input int n);
        @(negedge clk);
        case (k)
            0: fb[ch] = 1'b1;
            1: ovc[ch] = 1'b1;
            default: shl[ch] = 1'b1;
        endcase
        cyc(n);
        fb[ch]  = 1'b0;
        ovc[ch] = 1'b0;
        shl[ch] = 1'b0;
        cyc(3);
    endtask : hold

    task automatic wait_run(input int ch);
        for (int i = 0; i < 60 && gen[ch] !== 1'b1; i++) cyc(1);
        chk("gate_en", 8'h1, 8'(gen[ch]));
    endtask : wait_run

    task automatic print_verdict();
        if (bad_count == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : print_verdict

    initial begin
        repeat (5000) @(posedge clk);
        bad_count++;
        print_verdict();
    end

    initial begin
        {rstn, idle, limp, ots, otw, guv, luv} = 7'h0;
        {strap, fb, ovc, shl, blk, ssd, pwm, iof} = 16'h0;
        lvl = 4'h0;
        rs = 32'd51477;
        bad_count = 0;
        n_checks = 0;
        cyc(8);
        chk("threshold", 8'h22, thr);
        rstn = 1'b1;
        wait_run(0);
        hold(0, 0, 12);
        chk("flag", 8'h0, 8'(flg));
        blk = 2'h3;
        ssd = 2'h3;
        hold(0, 0, 7);
        hold(0, 0, 7);
        chk("flag", 8'h0, 8'(flg));
        hold(0, 0, 8);
        chk("flag", 8'h1, 8'(flg));
        chk("gate_en", 8'h0, 8'(gen[0]));
        ssd = 2'h0;
        wait_run(0);
        chk("soft", 8'h1, 8'(sst[0]));
        ssd = 2'h3;
        i_lfm_mcu_model.access(2'h2, 0, 4'h0);
        es = 2'h0;
        et = 8'h22;
        for (int k = 0; k < 16; k++) begin
            v = xs();
            strap = k[1:0];
            {lvl, iof, pwm} = v[7:0];
            es[v[8]] = v[9];
            et[v[8] * 4 +: 4] = v[13:10];
            i_lfm_mcu_model.access(2'h0, int'(v[8]), {3'h0, v[9]});
            i_lfm_mcu_model.access(2'h1, int'(v[8]), v[13:10]);
            cyc(2);
            chk("mon_sel", 8'(es), 8'(msel));
            chk("mon_pin", 8'(mon_exp(strap, es)), 8'(mpin));
            chk("threshold", et, thr);
            chk("level", 8'(lvl), 8'(cl));
        end
        limp = 1'b1;
        cyc(2);
        limp = 1'b0;
        cyc(1);
        chk("threshold", 8'h22, thr);
        chk("mon_sel", 8'h0, 8'(msel));
        strap = 2'h2;
        hold(1, 0, 4);
        chk("flag", 8'h0, 8'(flg));
        wait_run(1);
        hold(1, 1, 1);
        chk("flag", 8'h0, 8'(flg));
        hold(1, 1, 2);
        chk("flag", 8'h2, 8'(flg));
        i_lfm_mcu_model.access(2'h2, 1, 4'h0);
        wait_run(1);
        // A sense-pin short pulls the boost monitor pin low while it is seen.
        pwm = 2'h3;
        shl[1] = 1'b1;
        cyc(3);
        chk("mon_pin", 8'h0, 8'(mpin[1]));
        shl[1] = 1'b0;
        cyc(3);
        chk("flag", 8'h2, 8'(flg));
        // Idle starts on the very edge at which the feedback count completes.
        fb[0] = 1'b1;
        cyc(7);
        {idle, otw, guv, luv} = 4'hf;
        cyc(3);
        fb[0] = 1'b0;
        chk("faults", 8'h7, 8'({fw, fg, fl}));
        chk("flag", 8'h2, 8'(flg));
        {idle, otw, guv, luv} = 4'h0;
        wait_run(0);
        ots = 1'b1;
        cyc(2);
        chk("ot", 8'h2, 8'({fo, gen[0]}));
        ots = 1'b0;
        wait_run(0);
        print_verdict();
    end
endmodule : lfm_fault_mon_tb

`default_nettype wire
